// ### bsu_defs.svh
`ifndef BSU_DEFS_SVH
`define BSU_DEFS_SVH
// How it works
// - Unlock requests use frame type 2C hex, device replies use AC hex.
// - SRP uses 1024-bit group and SHA-256; arithmetic lives outside this block.
// - SRP identity is always the fixed text apiservice.
// - Step byte at offset 4: 1 A, 2 B and salt, 3 M1, 4 M2 and nonces.
// - Client sends 128-byte A starting at frame offset 5.
// - Client sends 32-byte proof M1 starting at offset 5.
// - Post-unlock traffic uses AES-256 counter mode with the 32-byte key.
// - Counter block is 96-bit nonce plus counter field starting at 1.
// - Client-to-device uses transmit nonce, device-to-client uses receive nonce.
// - Client may split writes, takes multi-part replies, acknowledges each indication.
`define BSU_FT_REQ    8'h2C
`define BSU_FT_RSP    8'hAC
`define BSU_ST_A      8'h01
`define BSU_ST_B      8'h02
`define BSU_ST_M1     8'h03
`define BSU_ST_M2     8'h04
`define BSU_ST_ERR    8'h80
`define BSU_OFS_TYPE  8'h03
`define BSU_OFS_STEP  8'h04
`define BSU_OFS_PAY   8'h05
`define BSU_OFS_B     8'h09
`define BSU_OFS_TXN   8'h25
`define BSU_OFS_RXN   8'h31
`define BSU_LEN_A     8'h80
`define BSU_LEN_B2    8'h84
`define BSU_LEN_M1    8'h20
`define BSU_LEN_M4    8'h38
`define BSU_LEN_NONCE 8'h0C
`define BSU_CTR_INIT  32'h0000_0001
`define BSU_ERR_NONE  8'h00
`define BSU_ERR_TYPE  8'hF0
`define BSU_ERR_ORDER 8'hF1
`define BSU_ERR_LEN   8'hF2
`define BSU_ERR_PROOF 8'hF3
`define BSU_ERR_LINK  8'hF4
`endif

// ### bsu_pkg.sv
package bsu_pkg;
  typedef enum logic [2:0] {
    BSU_IDLE    = 3'b000,
    BSU_SEND_A  = 3'b001,
    BSU_WAIT_B  = 3'b010,
    BSU_SEND_M1 = 3'b011,
    BSU_WAIT_M2 = 3'b100,
    BSU_VERIFY  = 3'b101,
    BSU_OPEN    = 3'b110,
    BSU_FAIL    = 3'b111
  } bsu_state_t;
endpackage

// ### bsu_fifo.sv
module bsu_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          push, pop;

  // Honest flags straight from the fill count
  assign in_ready  = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rp_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointers wrap at depth so any D works, not only powers of two
  always_comb begin
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    cnt_next = cnt_reg;
    if (push) wp_next = (wp_reg == AW'(D - 1)) ? '0 : wp_reg + AW'(1);
    if (pop) rp_next = (rp_reg == AW'(D - 1)) ? '0 : rp_reg + AW'(1);
    if (push && !pop) cnt_next = cnt_reg + (AW+1)'(1);
    else if (pop && !push) cnt_next = cnt_reg - (AW+1)'(1);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else if (clk_en) begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge ref_clk) begin
    if (clk_en && push) mem_reg[wp_reg] <= in_data;
  end
endmodule // bsu_fifo

// ### bsu_host.sv
`include "bsu_defs.svh"
module bsu_host
  import bsu_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         start,
  input  wire logic         link_up,
  input  wire logic         m2_ok,
  input  wire logic         m2_bad,
  input  wire logic         usr_valid,
  output logic              usr_ready,
  input  wire logic [7:0]   usr_data,
  output logic              tx_valid,
  input  wire logic         tx_ready,
  output logic [7:0]        tx_data,
  output logic              tx_last,
  input  wire logic         rx_valid,
  input  wire logic [7:0]   rx_data,
  input  wire logic         rx_last,
  output logic              ind_ack,
  output logic              pay_valid,
  output logic [7:0]        pay_data,
  output logic [7:0]        pay_step,
  output logic [7:0]        pay_ofs,
  input  wire logic         ks_tx_req,
  output logic [127:0]      ks_tx_blk,
  input  wire logic         ks_rx_req,
  output logic [127:0]      ks_rx_blk,
  output logic              unlocked,
  output logic              busy,
  output logic              failed,
  output logic [7:0]        err_code
);
  // Last frame offset for a given step; shared by sender and parser
  function automatic logic [7:0] frame_end(input logic [7:0] step);
    case (step)
      `BSU_ST_A:  frame_end = `BSU_OFS_PAY + `BSU_LEN_A - 8'h01;
      `BSU_ST_B:  frame_end = `BSU_OFS_PAY + `BSU_LEN_B2 - 8'h01;
      `BSU_ST_M1: frame_end = `BSU_OFS_PAY + `BSU_LEN_M1 - 8'h01;
      default:    frame_end = `BSU_OFS_PAY + `BSU_LEN_M4 - 8'h01;
    endcase
  endfunction

  bsu_state_t   state_reg, state_next;
  logic [7:0]   tofs_reg, tofs_next;
  logic [7:0]   rofs_reg, rofs_next;
  logic [7:0]   rstep_reg, rstep_next;
  logic         rbad_reg, rbad_next;
  logic [7:0]   err_reg, err_next;
  logic         txv_reg, txv_next;
  logic [7:0]   txd_reg, txd_next;
  logic         txl_reg, txl_next;
  logic         ack_reg, ack_next;
  logic         pv_reg, pv_next;
  logic [7:0]   pd_reg, pd_next;
  logic [7:0]   ps_reg, ps_next;
  logic [7:0]   po_reg, po_next;
  logic [95:0]  txn_reg, txn_next;
  logic [95:0]  rxn_reg, rxn_next;
  logic [31:0]  txc_reg, txc_next;
  logic [31:0]  rxc_reg, rxc_next;
  logic         f_valid, f_pop;
  logic [7:0]   f_data;
  logic         can_load, sending;
  logic [7:0]   tstep, step_now, want;

  // Payload bytes of A and M1 queue here; usr_ready stalls the source when full
  bsu_fifo #(
    .W (8),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_valid  (usr_valid),
    .in_ready  (usr_ready),
    .in_data   (usr_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  assign sending  = (state_reg == BSU_SEND_A) || (state_reg == BSU_SEND_M1);
  assign tstep    = (state_reg == BSU_SEND_A) ? `BSU_ST_A : `BSU_ST_M1;
  assign can_load = !txv_reg || tx_ready;
  assign step_now = (rofs_reg == `BSU_OFS_STEP) ? rx_data : rstep_reg;
  assign want     = (state_reg == BSU_WAIT_B) ? `BSU_ST_B : `BSU_ST_M2;
  assign f_pop    = sending && can_load && (tofs_reg >= `BSU_OFS_PAY) && f_valid;

  // Handshake sequencer, frame builder and reply parser
  always_comb begin
    state_next = state_reg;
    tofs_next  = tofs_reg;
    rofs_next  = rofs_reg;
    rstep_next = rstep_reg;
    rbad_next  = rbad_reg;
    err_next   = err_reg;
    txv_next   = txv_reg && !tx_ready;
    txd_next   = txd_reg;
    txl_next   = txl_reg;
    ack_next   = rx_valid && rx_last;
    pv_next    = 1'b0;
    pd_next    = pd_reg;
    ps_next    = ps_reg;
    po_next    = po_reg;
    // Reply bytes are only parsed while a reply is expected
    if (rx_valid && (state_reg == BSU_WAIT_B || state_reg == BSU_WAIT_M2)) begin
      rofs_next = rofs_reg + 8'h01;
      if (rofs_reg == `BSU_OFS_TYPE && rx_data != `BSU_FT_RSP) rbad_next = 1'b1;
      if (rofs_reg == `BSU_OFS_STEP) rstep_next = rx_data;
      if (rofs_reg >= `BSU_OFS_PAY) begin
        pv_next = 1'b1;
        pd_next = rx_data;
        ps_next = rstep_reg;
        po_next = rofs_reg;
      end
      if (rx_last) begin
        rofs_next = `BSU_OFS_TYPE;
        rbad_next = 1'b0;
        if (rbad_reg || (rofs_reg == `BSU_OFS_TYPE && rx_data != `BSU_FT_RSP)) begin
          state_next = BSU_FAIL;
          err_next   = `BSU_ERR_TYPE;
        end else if (step_now >= `BSU_ST_ERR) begin
          state_next = BSU_FAIL;
          err_next   = step_now;
        end else if (step_now != want) begin
          state_next = BSU_FAIL;
          err_next   = `BSU_ERR_ORDER;
        end else if (rofs_reg != frame_end(want)) begin
          state_next = BSU_FAIL;
          err_next   = `BSU_ERR_LEN;
        end else begin
          state_next = (state_reg == BSU_WAIT_B) ? BSU_SEND_M1 : BSU_VERIFY;
        end
      end
    end
    case (state_reg)
      BSU_IDLE, BSU_FAIL: begin
        // Identity and group are fixed; software supplies A computed accordingly
        if (start && link_up) begin
          state_next = BSU_SEND_A;
          tofs_next  = `BSU_OFS_TYPE;
          rofs_next  = `BSU_OFS_TYPE;
          rbad_next  = 1'b0;
          err_next   = `BSU_ERR_NONE;
        end
      end
      BSU_SEND_A, BSU_SEND_M1: begin
        // One byte per accepted write; the link may cut it into several writes
        if (can_load && tofs_reg < `BSU_OFS_PAY) begin
          txv_next  = 1'b1;
          txl_next  = 1'b0;
          txd_next  = (tofs_reg == `BSU_OFS_TYPE) ? `BSU_FT_REQ : tstep;
          tofs_next = tofs_reg + 8'h01;
        end else if (f_pop) begin
          txv_next = 1'b1;
          txd_next = f_data;
          txl_next = (tofs_reg == frame_end(tstep));
          if (tofs_reg == frame_end(tstep)) begin
            tofs_next  = `BSU_OFS_TYPE;
            state_next = (state_reg == BSU_SEND_A) ? BSU_WAIT_B : BSU_WAIT_M2;
          end else begin
            tofs_next = tofs_reg + 8'h01;
          end
        end
      end
      BSU_VERIFY: begin
        // Key stays unusable until software has checked M2
        if (m2_ok) begin
          state_next = BSU_OPEN;
        end else if (m2_bad) begin
          state_next = BSU_FAIL;
          err_next   = `BSU_ERR_PROOF;
        end
      end
      default: begin
      end
    endcase
    // Link loss ends the session; mid-handshake it is a failure
    if (!link_up && state_reg != BSU_IDLE && state_reg != BSU_FAIL) begin
      state_next = (state_reg == BSU_OPEN) ? BSU_IDLE : BSU_FAIL;
      err_next   = (state_reg == BSU_OPEN) ? `BSU_ERR_NONE : `BSU_ERR_LINK;
      txv_next   = 1'b0;
      txl_next   = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BSU_IDLE;
      tofs_reg  <= `BSU_OFS_TYPE;
      rofs_reg  <= `BSU_OFS_TYPE;
      rstep_reg <= 8'h00;
      rbad_reg  <= 1'b0;
      err_reg   <= `BSU_ERR_NONE;
      txv_reg   <= 1'b0;
      txd_reg   <= 8'h00;
      txl_reg   <= 1'b0;
      ack_reg   <= 1'b0;
      pv_reg    <= 1'b0;
      pd_reg    <= 8'h00;
      ps_reg    <= 8'h00;
      po_reg    <= 8'h00;
    end else if (clk_en) begin
      state_reg <= state_next;
      tofs_reg  <= tofs_next;
      rofs_reg  <= rofs_next;
      rstep_reg <= rstep_next;
      rbad_reg  <= rbad_next;
      err_reg   <= err_next;
      txv_reg   <= txv_next;
      txd_reg   <= txd_next;
      txl_reg   <= txl_next;
      ack_reg   <= ack_next;
      pv_reg    <= pv_next;
      pd_reg    <= pd_next;
      ps_reg    <= ps_next;
      po_reg    <= po_next;
    end
  end

  // Nonce capture and per-direction counters
  always_comb begin
    txn_next = txn_reg;
    rxn_next = rxn_reg;
    txc_next = txc_reg;
    rxc_next = rxc_reg;
    if (rx_valid && state_reg == BSU_WAIT_M2 && rstep_reg == `BSU_ST_M2) begin
      if (rofs_reg >= `BSU_OFS_TXN && rofs_reg < `BSU_OFS_RXN)
        txn_next = {txn_reg[87:0], rx_data};
      else if (rofs_reg >= `BSU_OFS_RXN && rofs_reg < `BSU_OFS_RXN + `BSU_LEN_NONCE)
        rxn_next = {rxn_reg[87:0], rx_data};
    end
    if (state_reg == BSU_VERIFY && m2_ok) begin
      txc_next = `BSU_CTR_INIT;
      rxc_next = `BSU_CTR_INIT;
    end else if (state_reg == BSU_OPEN) begin
      // Counters never rewind within a session, frames or not
      if (ks_tx_req) txc_next = txc_reg + 32'h0000_0001;
      if (ks_rx_req) rxc_next = rxc_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txn_reg <= 96'h0;
      rxn_reg <= 96'h0;
      txc_reg <= `BSU_CTR_INIT;
      rxc_reg <= `BSU_CTR_INIT;
    end else if (clk_en) begin
      txn_reg <= txn_next;
      rxn_reg <= rxn_next;
      txc_reg <= txc_next;
      rxc_reg <= rxc_next;
    end
  end

  // Blocks feed an external AES-256 engine keyed by the session key
  assign ks_tx_blk = {txn_reg, txc_reg};
  assign ks_rx_blk = {rxn_reg, rxc_reg};
  assign tx_valid  = txv_reg;
  assign tx_data   = txd_reg;
  assign tx_last   = txl_reg;
  assign ind_ack   = ack_reg;
  assign pay_valid = pv_reg;
  assign pay_data  = pd_reg;
  assign pay_step  = ps_reg;
  assign pay_ofs   = po_reg;
  assign unlocked  = (state_reg == BSU_OPEN);
  assign busy      = (state_reg != BSU_IDLE) && (state_reg != BSU_FAIL) && (state_reg != BSU_OPEN);
  assign failed    = (state_reg == BSU_FAIL);
  assign err_code  = err_reg;
endmodule // bsu_host

// ### bsu_chk_asserts.sv
module bsu_chk #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic         ref_clk,
  input wire logic         rst_n,
  input wire logic         clk_en,
  input wire logic         link_up,
  input wire logic         m2_ok,
  input wire logic         tx_valid,
  input wire logic         tx_ready,
  input wire logic [7:0]   tx_data,
  input wire logic         tx_last,
  input wire logic         rx_valid,
  input wire logic         rx_last,
  input wire logic         ind_ack,
  input wire logic         pay_valid,
  input wire logic [7:0]   pay_ofs,
  input wire logic         ks_tx_req,
  input wire logic [127:0] ks_tx_blk,
  input wire logic [127:0] ks_rx_blk,
  input wire logic         unlocked,
  input wire logic         busy,
  input wire logic         failed,
  input wire logic [7:0]   err_code
);
  logic at_start_reg;
  logic at_start_next;
  // Next accepted byte heads a frame; an aborted frame restarts at the head too
  always_comb begin
    at_start_next = at_start_reg;
    if (!busy) at_start_next = 1'b1;
    else if (tx_valid && tx_ready && clk_en) at_start_next = tx_last;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) at_start_reg <= 1'b1;
    else at_start_reg <= at_start_next;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_last_taken;
    rx_valid && rx_last && clk_en;
  endsequence
  sequence s_head_taken;
    tx_valid && tx_ready && clk_en && at_start_reg;
  endsequence
  a_ack_follows: assert property (s_last_taken |=> ind_ack) else $error("no ack after reply end");
  a_ack_cause: assert property (ind_ack && $past(clk_en) |-> $past(rx_valid && rx_last))
    else $error("ack without reply end");
  a_tx_hold: assert property (tx_valid && !tx_ready && link_up && clk_en |=> tx_valid && $stable(tx_data)
    && $stable(tx_last)) else $error("frame byte not held");
  a_head_type: assert property (tx_valid && at_start_reg |-> tx_data == 8'h2C) else $error("bad frame type");
  a_head_step: assert property (s_head_taken |=> tx_data inside {8'h01, 8'h03}) else $error("bad step");
  a_unlock_cause: assert property ($rose(unlocked) |-> $past(m2_ok)) else $error("unlock without proof");
  a_open_quiet: assert property (unlocked |-> !busy && !failed && err_code == 8'h00)
    else $error("open while busy");
  a_ctr_start: assert property ($rose(unlocked) |-> ks_tx_blk[31:0] == 32'h1 && ks_rx_blk[31:0] == 32'h1)
    else $error("counter not one");
  a_ctr_step: assert property (unlocked && ks_tx_req && clk_en && link_up |=> ks_tx_blk[31:0] ==
    $past(ks_tx_blk[31:0]) + 32'h1 && $stable(ks_tx_blk[127:32])) else $error("counter step");
  a_fail_code: assert property ($rose(failed) |-> err_code >= 8'h80) else $error("failure without code");
  a_pay_offset: assert property (pay_valid |-> pay_ofs >= 8'h05 && pay_ofs <= 8'h88)
    else $error("payload offset");
endmodule // bsu_chk

bind bsu_host bsu_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.ref_clk, .rst_n, .clk_en, .link_up, .m2_ok, .tx_valid,
  .tx_ready, .tx_data, .tx_last, .rx_valid, .rx_last, .ind_ack, .pay_valid, .pay_ofs, .ks_tx_req, .ks_tx_blk,
  .ks_rx_blk, .unlocked, .busy, .failed, .err_code);

// ### bsu_dev_model.sv
module bsu_dev #(
  parameter int api_mode_setting = 1
) (
  input  wire logic        ref_clk,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_last,
  output logic             tx_ready,
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  output logic             rx_last,
  input  wire logic [7:0]  err_step,
  input  wire logic [95:0] txn,
  input  wire logic [95:0] rxn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  rq[$];
  logic [7:0]  rp[$];
  logic [23:0] pl[$];
  logic        dropped;
  logic [7:0]  modem_status;
  initial begin
    dropped = 1'b0;
    modem_status = 8'h00;
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
  end
  // A reply is queued whole once the request frame is complete, never earlier
  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready) begin
      rq.push_back(tx_data);
      if (tx_last) begin
        // An all-zero A makes the device hang up instead of answering
        dropped = rq[1] == 8'h01 && err_step == 8'h00;
        foreach (rq[i]) if (i >= 2 && rq[i] != 8'h00) dropped = 1'b0;
        // Device side announces the unlock as soon as it queues its proof, before any of it is sent
        if (rq[1] == 8'h03 && err_step == 8'h00)
          modem_status = (api_mode_setting inside {1, 2}) ? 8'h32 : 8'h00;
        if (!dropped) rp = {8'hAC, (err_step != 8'h00) ? err_step : rq[1] + 8'h01};
        for (int i = 0; i < ((err_step != 8'h00 || dropped) ? 0 : (rq[1] == 8'h01) ? 132 : 56); i++) begin
          rp.push_back((rq[1] == 8'h03 && i >= 32) ? ((i < 44) ? txn[(43 - i) * 8 +: 8]
            : rxn[(55 - i) * 8 +: 8]) : 8'($urandom));
          pl.push_back({rp[1], 8'(i + 5), rp[i + 2]});
        end
        rq = {};
      end
    end
    #1;
    tx_ready = ($urandom % 4) != 0; // Stalls one cycle in four
    rx_valid = rp.size() > 0 && ($urandom % 3) != 0;
    rx_data = rx_valid ? rp.pop_front() : ~rx_data; // Idle line inverts the previous cycle's byte instead of holding it
    rx_last = rx_valid && rp.size() == 0;
  end
endmodule // bsu_dev

// ### testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic         ref_clk, rst_n, clk_en, start, link_up, m2_ok, m2_bad;
  logic         usr_valid, usr_ready, tx_valid, tx_ready, tx_last, rx_valid, rx_last, ind_ack;
  logic         pay_valid, ks_tx_req, ks_rx_req, unlocked, busy, failed;
  logic [7:0]   usr_data, tx_data, rx_data, pay_data, pay_step, pay_ofs, err_code, dev_err;
  logic [95:0]  txn, rxn;
  logic [127:0] ks_tx_blk, ks_rx_blk;
  logic [31:0]  ct, cr;
  logic [8:0]   exq[$];
  int           mismatches, n_compared, cyc;
  bsu_host #(.FIFO_DEPTH(8)) dut (.ref_clk, .rst_n, .clk_en, .start, .link_up, .m2_ok, .m2_bad, .usr_valid,
    .usr_ready, .usr_data, .tx_valid, .tx_ready, .tx_data, .tx_last, .rx_valid, .rx_data, .rx_last, .ind_ack,
    .pay_valid, .pay_data, .pay_step, .pay_ofs, .ks_tx_req, .ks_tx_blk, .ks_rx_req, .ks_rx_blk, .unlocked,
    .busy, .failed, .err_code);
  bsu_dev dev (.ref_clk, .tx_valid, .tx_data, .tx_last, .tx_ready, .rx_valid, .rx_data, .rx_last,
    .err_step(dev_err), .txn, .rxn);
  task chk(input string nm, input logic [127:0] got, input logic [127:0] ex);
    n_compared++;
    if (got !== ex) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task results;
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Fills the buffer until it refuses before starting, so the first frame drains a full FIFO
  task push(input int n, input logic [7:0] stp, input logic [7:0] msk);
    logic [7:0] d;
    exq.push_back({1'b0, 8'h2C});
    exq.push_back({1'b0, stp});
    for (int i = 0; i < n; i++) begin
      if (i == 8 && stp == 8'h01) begin
        chk("fifo_full", usr_ready, 1'b0);
        start = 1'b1;
        @(posedge ref_clk);
        #1;
        start = 1'b0;
      end
      d = 8'($urandom) & msk;
      usr_valid = 1'b1;
      usr_data = d;
      exq.push_back({i == n - 1, d});
      // usr_ready only moves at edges, so its settled value holds at the next one
      while (usr_ready !== 1'b1) begin
        @(posedge ref_clk);
        #1;
      end
      @(posedge ref_clk);
      #1;
    end
    usr_valid = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  task wait_ack;
    do begin
      @(posedge ref_clk);
      #1;
    end while (ind_ack !== 1'b1);
  endtask
  // One handshake; a nonzero code makes the device refuse at step two
  task hs(input logic [7:0] es, input logic ok);
    dev_err = es;
    txn = {$urandom, $urandom, $urandom};
    rxn = {$urandom, $urandom, $urandom};
    push(128, 8'h01, 8'hFF);
    if (es != 8'h00) begin
      wait_ack();
      chk("fail_code", {failed, err_code}, {1'b1, es});
    end else begin
      push(32, 8'h03, 8'hFF);
      wait_ack();
      m2_ok = ok;
      m2_bad = !ok;
      @(posedge ref_clk);
      #1;
      m2_ok = 1'b0;
      m2_bad = 1'b0;
      chk("verify", {unlocked, failed, err_code & {8{!ok}}}, ok ? 10'h200 : 10'h1F3);
    end
  endtask
  always #4 ref_clk = ~ref_clk;
  // Cuts a hang short; the whole run needs well under a third of this
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end
  // Each accepted frame byte and each reply payload byte meets its model value
  always @(posedge ref_clk) begin
    if (rst_n && tx_valid && tx_ready) chk("tx_byte", {tx_last, tx_data}, exq.pop_front());
    if (pay_valid) chk("pay_byte", {pay_step, pay_ofs, pay_data}, dev.pl.pop_front());
  end
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    link_up = 1'b1;
    {start, m2_ok, m2_bad, usr_valid, ks_tx_req, ks_rx_req} = 6'h00;
    usr_data = 8'h00;
    dev_err = 8'h00;
    void'($urandom(32'h5F9658DE));
    repeat (4) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    chk("rst_state", {usr_ready, unlocked, busy, failed, err_code, ks_tx_blk[31:0]}, {4'h8, 8'h00, 32'h1});
    // Keystream requests before unlock must not move either counter
    {ks_tx_req, ks_rx_req} = 2'b11;
    @(posedge ref_clk);
    #1;
    {ks_tx_req, ks_rx_req} = 2'b00;
    chk("locked_ks", {ks_tx_blk[31:0], ks_rx_blk[31:0]}, 64'h0000_0001_0000_0001);
    for (int e = 8'h80; e <= 8'h84; e++) hs(8'(e), 1'b0);
    // A zero A value: the device hangs up mid-handshake
    dev_err = 8'h00;
    push(128, 8'h01, 8'h00);
    while (dev.dropped !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    link_up = 1'b0;
    @(posedge ref_clk);
    #1;
    link_up = 1'b1;
    chk("link_drop", {failed, err_code}, {1'b1, 8'hF4});
    hs(8'h00, 1'b0);
    hs(8'h00, 1'b1);
    chk("unlock_view", unlocked, dev.modem_status == 8'h32);
    ct = 32'h1;
    cr = 32'h1;
    repeat (24) begin
      chk("ks_tx", ks_tx_blk, {txn, ct});
      chk("ks_rx", ks_rx_blk, {rxn, cr});
      ks_tx_req = 1'($urandom);
      ks_rx_req = 1'($urandom);
      clk_en = ($urandom % 4) != 0; // A frozen cycle must hold both counters
      @(posedge ref_clk);
      #1;
      ct += ks_tx_req && clk_en;
      cr += ks_rx_req && clk_en;
    end
    {ks_tx_req, ks_rx_req} = 2'b00;
    clk_en = 1'b1;
    link_up = 1'b0;
    @(posedge ref_clk);
    #1;
    link_up = 1'b1;
    chk("link_end", {unlocked, busy, failed, err_code}, 11'h000);
    chk("left_over", exq.size() + dev.pl.size(), 0);
    results();
  end
endmodule // testbench
